// file: rtl/crce_params.svh
`ifndef CRCE_PARAMS_SVH
`define CRCE_PARAMS_SVH
`define CRCE_POLY_CCITT 32'h0000_1021
`define CRCE_POLY_CRC16 32'h0000_8005
`define CRCE_POLY_CRC32 32'h04C1_1DB7
`define CRCE_FIFO_DEPTH 8
`define CRCE_FIFO_AW 3
`define CRCE_WORD_W 32
`define CRCE_ENTRY_W 34
`define CRCE_SEED_RESET 32'h0000_0000
`define CRCE_SUM_RESET 32'h0000_0000
`define CRCE_BYTE_W 8
`define CRCE_SIZE_LSB 32
`define CRCE_SIZE_MSB 33
`define CRCE_LEFT_BYTE 2'h0
`define CRCE_LEFT_HALF 2'h1
`define CRCE_LEFT_WORD 2'h3
`define CRCE_LAST_BYTE 2'h0
`define CRCE_WIDE_MSB 31
`define CRCE_NARROW_MSB 15
`define CRCE_NARROW_W 16
`define CRCE_NARROW_MASK 32'h0000_FFFF
`define CRCE_WIDE_MASK 32'hFFFF_FFFF
`endif

// file: rtl/crce_pkg.sv
package crce_pkg;
  typedef enum logic [1:0] {
    CRCE_SEL_CCITT,
    CRCE_SEL_CRC16,
    CRCE_SEL_CRC32,
    CRCE_SEL_RSVD
  } crce_poly_type;
  typedef enum logic [1:0] {
    CRCE_SIZE_BYTE,
    CRCE_SIZE_HALF,
    CRCE_SIZE_WORD,
    CRCE_SIZE_RSVD
  } crce_size_type;
endpackage

// file: rtl/crce_engine.sv
// Overview of operation
// - Polynomial selectable: CCITT 16-bit, CRC-16 16-bit, or CRC-32 32-bit.
// - Separate bit-reverse and ones-complement options for input data and result.
// - Software loads a seed into the checksum register before a calculation.
// - Back-to-back writes from processor or DMA buffered; the writer stalls only when eight entries wait.
// - Writes of 8, 16 or 32 bits each feed the running checksum.
// - One byte per cycle: one, two or four cycles per write.
`include "crce_params.svh"

module crce_fifo #(
  parameter int WIDTH = `CRCE_ENTRY_W,
  parameter int DEPTH = `CRCE_FIFO_DEPTH,
  parameter int AW = `CRCE_FIFO_AW
) (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_srst,
  // Fill side
  input wire logic i_valid,
  output logic o_ready,
  input wire logic [WIDTH-1:0] i_data,
  // Drain side
  output logic o_valid,
  input wire logic i_ready,
  output logic [WIDTH-1:0] o_data
);
  // ==========================================
  // Storage
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0] wr_reg;
  logic [AW-1:0] rd_reg;
  logic [AW:0] count_reg;
  wire push = i_valid && o_ready;
  wire pop = o_valid && i_ready;
  // Full still takes a word while the head leaves in the same cycle
  assign o_ready = (count_reg != (AW + 1)'(DEPTH)) || i_ready;
  assign o_valid = (count_reg != '0);
  assign o_data = mem_reg[rd_reg];
  always_ff @(posedge i_clock) begin
    if (push) begin
      mem_reg[wr_reg] <= i_data;
    end
  end

  // ==========================================
  // Pointers
  // Wrap compares keep depths that are not a power of two usable
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      wr_reg <= '0;
      rd_reg <= '0;
      count_reg <= '0;
    end else begin
      if (push) begin
        wr_reg <= (wr_reg == AW'(DEPTH - 1)) ? '0 : wr_reg + 1'b1;
      end
      if (pop) begin
        rd_reg <= (rd_reg == AW'(DEPTH - 1)) ? '0 : rd_reg + 1'b1;
      end
      count_reg <= count_reg + (AW + 1)'(push) - (AW + 1)'(pop);
    end
  end

  // ==========================================
  // Checks
  fifo_bound_a: assert property (@(posedge i_clock) disable iff (i_srst)
    count_reg <= (AW + 1)'(DEPTH))
    else $error("fifo count past depth");
  fifo_room_a: assert property (@(posedge i_clock) disable iff (i_srst)
    (count_reg < (AW + 1)'(DEPTH)) |-> o_ready)
    else $error("fifo refused with room");
  fifo_hold_a: assert property (@(posedge i_clock) disable iff (i_srst)
    (o_valid && !i_ready) |=> o_valid && $stable(o_data))
    else $error("fifo head lost");
endmodule

module crce_engine
  import crce_pkg::*;
(
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_srst,
  // Configuration
  input wire crce_poly_type i_poly_sel,
  input wire logic i_data_reverse,
  input wire logic i_data_complement,
  input wire logic i_sum_reverse,
  input wire logic i_sum_complement,
  // Seed load
  input wire logic i_seed_load,
  input wire logic [31:0] i_seed,
  // Data write
  input wire logic i_wr_valid,
  output logic o_wr_ready,
  input wire crce_size_type i_wr_size,
  input wire logic [31:0] i_wr_data,
  // Result and status
  output logic [31:0] o_sum,
  output logic o_busy
);
  // ==========================================
  // Input buffer
  logic fifo_valid;
  logic fifo_ready;
  logic [`CRCE_ENTRY_W-1:0] fifo_data;
  // Back-pressure: writer stalls only when eight words wait
  crce_fifo #(
    .WIDTH(`CRCE_ENTRY_W),
    .DEPTH(`CRCE_FIFO_DEPTH),
    .AW(`CRCE_FIFO_AW)
  ) u_fifo (
    .i_clock(i_clock),
    .i_srst(i_srst),
    .i_valid(i_wr_valid),
    .o_ready(o_wr_ready),
    .i_data({i_wr_size, i_wr_data}),
    .o_valid(fifo_valid),
    .i_ready(fifo_ready),
    .o_data(fifo_data)
  );

  // ==========================================
  // Byte sequencer
  typedef enum logic {CRCE_IDLE, CRCE_RUN} crce_state_type;
  crce_state_type state_reg;
  crce_state_type state_next;
  logic [31:0] word_reg;
  logic [31:0] word_next;
  logic [1:0] left_reg;
  logic [1:0] left_next;
  logic [1:0] entry_left;
  logic [31:0] entry_word;
  crce_size_type entry_size;
  logic [7:0] cur_byte;
  logic byte_valid;

  // Bytes still to come after the first one; reserved code runs as a word
  function automatic logic [1:0] bytes_left(input crce_size_type code);
    unique case (code)
      CRCE_SIZE_BYTE: bytes_left = `CRCE_LEFT_BYTE;
      CRCE_SIZE_HALF: bytes_left = `CRCE_LEFT_HALF;
      default: bytes_left = `CRCE_LEFT_WORD;
    endcase
  endfunction

  assign entry_word = fifo_data[`CRCE_WORD_W-1:0];
  assign entry_size = crce_size_type'(fifo_data[`CRCE_SIZE_MSB:`CRCE_SIZE_LSB]);
  assign entry_left = bytes_left(entry_size);
  // Next entry pulled on the last byte, so writes run without gaps
  assign fifo_ready = (state_reg == CRCE_IDLE) || (left_reg == `CRCE_LAST_BYTE);
  assign byte_valid = (state_reg == CRCE_RUN);
  assign cur_byte = word_reg[`CRCE_BYTE_W-1:0];
  assign o_busy = (state_reg == CRCE_RUN) || fifo_valid;

  always_comb begin
    state_next = state_reg;
    word_next = word_reg;
    left_next = left_reg;
    unique case (state_reg)
      CRCE_IDLE: begin
        if (fifo_valid) begin
          state_next = CRCE_RUN;
          word_next = entry_word;
          left_next = entry_left;
        end
      end
      CRCE_RUN: begin
        if (left_reg != `CRCE_LAST_BYTE) begin
          word_next = word_reg >> `CRCE_BYTE_W;
          left_next = left_reg - 2'h1;
        end else if (fifo_valid) begin
          word_next = entry_word;
          left_next = entry_left;
        end else begin
          state_next = CRCE_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      state_reg <= CRCE_IDLE;
      word_reg <= '0;
      left_reg <= `CRCE_LAST_BYTE;
    end else begin
      state_reg <= state_next;
      word_reg <= word_next;
      left_reg <= left_next;
    end
  end

  // ==========================================
  // Checksum datapath
  function automatic logic [31:0] poly_of(input crce_poly_type sel);
    unique case (sel)
      CRCE_SEL_CCITT: poly_of = `CRCE_POLY_CCITT;
      CRCE_SEL_CRC16: poly_of = `CRCE_POLY_CRC16;
      default: poly_of = `CRCE_POLY_CRC32;
    endcase
  endfunction
  function automatic logic [31:0] rev32(input logic [31:0] v);
    for (int i = 0; i < 32; i++) begin
      rev32[i] = v[31-i];
    end
  endfunction

  logic [31:0] crc_reg;
  logic [31:0] crc_next;
  logic [7:0] in_byte;
  logic wide;
  logic [31:0] poly;
  assign wide = (i_poly_sel == CRCE_SEL_CRC32) || (i_poly_sel == CRCE_SEL_RSVD);
  assign poly = poly_of(i_poly_sel);
  logic [7:0] byte_rev;
  // Reversal per byte keeps the feed order intact
  for (genvar i = 0; i < `CRCE_BYTE_W; i++) begin : g_byte_rev
    assign byte_rev[i] = cur_byte[`CRCE_BYTE_W-1-i];
  end
  assign in_byte = (i_data_reverse ? byte_rev : cur_byte) ^ {`CRCE_BYTE_W{i_data_complement}};

  always_comb begin
    logic msb;
    msb = 1'b0;
    crc_next = crc_reg;
    for (int b = `CRCE_BYTE_W - 1; b >= 0; b--) begin
      msb = (wide ? crc_next[`CRCE_WIDE_MSB] : crc_next[`CRCE_NARROW_MSB]) ^ in_byte[b];
      crc_next = {crc_next[30:0], 1'b0} ^ (msb ? poly : 32'h0);
      if (!wide) begin
        crc_next = crc_next & `CRCE_NARROW_MASK;
      end
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      crc_reg <= `CRCE_SEED_RESET;
    end else if (i_seed_load) begin
      crc_reg <= i_seed;
    end else if (byte_valid) begin
      crc_reg <= crc_next;
    end
  end

  // Result shaping; narrow sums reverse within 16 bits
  logic [31:0] crc_flip;
  logic [31:0] sum_rev;
  logic [31:0] sum_mask;
  logic [31:0] sum_shaped;
  assign crc_flip = rev32(crc_reg);
  assign sum_rev = wide ? crc_flip : (crc_flip >> `CRCE_NARROW_W);
  assign sum_mask = (wide ? `CRCE_WIDE_MASK : `CRCE_NARROW_MASK) & {`CRCE_WORD_W{i_sum_complement}};
  assign sum_shaped = (i_sum_reverse ? sum_rev : crc_reg) ^ sum_mask;
  // Registered so the sum never glitches while bytes fold in
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      o_sum <= `CRCE_SUM_RESET;
    end else begin
      o_sum <= sum_shaped;
    end
  end

  // ==========================================
  // Checks
  seed_load_a: assert property (@(posedge i_clock) disable iff (i_srst)
    i_seed_load |=> crc_reg == $past(i_seed))
    else $error("seed not loaded");
  word_len_a: assert property (@(posedge i_clock) disable iff (i_srst)
    (fifo_ready && fifo_valid && entry_size == CRCE_SIZE_WORD)
    |=> byte_valid [*4])
    else $error("word not four cycles");
  half_len_a: assert property (@(posedge i_clock) disable iff (i_srst)
    (fifo_ready && fifo_valid && entry_size == CRCE_SIZE_HALF)
    |=> byte_valid ##1 fifo_ready)
    else $error("half not two cycles");
  byte_len_a: assert property (@(posedge i_clock) disable iff (i_srst)
    (fifo_ready && fifo_valid && entry_size == CRCE_SIZE_BYTE)
    |=> byte_valid && fifo_ready)
    else $error("byte not one cycle");
  byte_order_a: assert property (@(posedge i_clock) disable iff (i_srst)
    (fifo_ready && fifo_valid) |=> cur_byte == $past(fifo_data[7:0]))
    else $error("low byte not first");
  no_gap_a: assert property (@(posedge i_clock) disable iff (i_srst)
    (byte_valid && fifo_ready && fifo_valid) |=> byte_valid)
    else $error("gap between writes");
  crc_hold_a: assert property (@(posedge i_clock) disable iff (i_srst)
    (!byte_valid && !$past(i_seed_load) && $past(!byte_valid)) |-> $stable(crc_reg))
    else $error("crc moved while idle");
  sum_path_a: assert property (@(posedge i_clock) disable iff (i_srst)
    (!i_sum_reverse && i_sum_complement && wide) |=> o_sum == ~$past(crc_reg))
    else $error("sum complement wrong");
  narrow_a: assert property (@(posedge i_clock) disable iff (i_srst)
    (!wide && !i_seed_load && byte_valid) |=> crc_reg[31:16] == 16'h0000)
    else $error("narrow crc upper bits set");
  data_rev_a: assert property (@(posedge i_clock) disable iff (i_srst)
    (byte_valid && i_data_reverse && !i_data_complement) |-> in_byte[0] == cur_byte[7] && in_byte[7] == cur_byte[0])
    else $error("input byte not mirrored");
  sum_rev_a: assert property (@(posedge i_clock) disable iff (i_srst)
    (i_sum_reverse && !i_sum_complement && wide) |=> o_sum[0] == $past(crc_reg[`CRCE_WIDE_MSB]))
    else $error("sum reverse wrong");
  mid_word_a: assert property (@(posedge i_clock) disable iff (i_srst)
    (byte_valid && left_reg != `CRCE_LAST_BYTE) |-> !fifo_ready)
    else $error("entry pulled mid write");
  seq_load_a: assert property (@(posedge i_clock) disable iff (i_srst)
    (state_reg == CRCE_IDLE && fifo_valid) |=> byte_valid && word_reg == $past(entry_word))
    else $error("idle entry not taken");
endmodule

// file: verif/crce_writer.sv
module crce_writer
  import crce_pkg::*;
(
  // Clock
  input wire logic i_clock,
  // Write side
  input wire logic i_wr_ready,
  output logic o_wr_valid,
  output crce_size_type o_wr_size,
  output logic [31:0] o_wr_data
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    o_wr_valid = 1'b0;
    o_wr_size = CRCE_SIZE_BYTE;
    o_wr_data = 32'h0;
  end
  // Released data flips so a stale word never looks valid
  task automatic idle();
    o_wr_valid = 1'b0;
    o_wr_data = ~o_wr_data;
  endtask
  // Request held until ready seen at an edge
  task automatic put(input logic [31:0] d, input crce_size_type s, input int gap);
    if (gap > 0) begin
      idle();
      repeat (gap) @(posedge i_clock);
      #1;
    end
    o_wr_valid = 1'b1;
    o_wr_size = s;
    o_wr_data = d;
    @(negedge i_clock);
    while (!i_wr_ready) @(negedge i_clock);
    @(posedge i_clock);
    #1;
  endtask
endmodule

// file: verif/crce_engine_tb.sv
`include "crce_params.svh"
module crce_engine_tb
  import crce_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin err_total++; \
  $display("wrong value at %0t: %h not %h", $time, a, b); end end
  logic clock = 0, srst = 1, dr = 0, dc = 0, sr = 0, sc = 0, ld = 0, valid, ready, busy;
  crce_poly_type poly = CRCE_SEL_CCITT;
  crce_size_type size;
  logic [31:0] seed = 32'h0, data, sum, crc, p, m;
  int err_total, num_checks, refused, w, cnt;
  always #5 clock = ~clock;
  always @(negedge clock) if (valid && !ready) refused++;
  crce_engine i_dut(.i_clock(clock), .i_srst(srst), .i_poly_sel(poly), .i_data_reverse(dr),
    .i_data_complement(dc), .i_sum_reverse(sr), .i_sum_complement(sc), .i_seed_load(ld),
    .i_seed(seed), .i_wr_valid(valid), .o_wr_ready(ready), .i_wr_size(size),
    .i_wr_data(data), .o_sum(sum), .o_busy(busy));
  crce_writer i_wr(.i_clock(clock), .i_wr_ready(ready), .o_wr_valid(valid),
    .o_wr_size(size), .o_wr_data(data));
  // ====
  // Reference model
  function automatic logic [31:0] rev(logic [31:0] v, int n);
    logic [31:0] r;
    r = 32'h0;
    for (int i = 0; i < n; i++) r[i] = v[n-1-i];
    return r;
  endfunction
  task automatic wr(logic [31:0] d, int s, int gap);
    logic [7:0] b;
    i_wr.put(d, crce_size_type'(s[1:0]), gap);
    for (int k = 0; k < (s == 0 ? 1 : s == 1 ? 2 : 4); k++) begin
      b = d[8*k +: 8];
      if (dr) b = 8'(rev(32'(b), 8));
      if (dc) b = ~b;
      for (int i = 7; i >= 0; i--) crc = ((crc << 1) ^ ((crc[w-1] ^ b[i]) ? p : 32'h0)) & m;
    end
  endtask
  // Config moves only while idle
  task automatic cfg(int t);
    poly = crce_poly_type'(t[1:0]);
    w = t % 4 < 2 ? 16 : 32;
    p = t % 4 == 0 ? `CRCE_POLY_CCITT : t % 4 == 1 ? `CRCE_POLY_CRC16 : `CRCE_POLY_CRC32;
    m = w == 32 ? 32'hFFFFFFFF : 32'h0000FFFF;
    {dr, dc, sr, sc} = 4'($urandom);
    seed = $urandom & m;
    ld = 1'b1;
    @(posedge clock);
    #1;
    ld = 1'b0;
    crc = seed;
  endtask
  task automatic fin(int t);
    logic [31:0] e;
    i_wr.idle();
    cnt = 0;
    while (busy !== 1'b0 && cnt < 200) begin
      @(posedge clock);
      #1;
      cnt++;
    end
    if (busy !== 1'b0) begin
      err_total++;
      $display("wrong value at %0t: engine stuck busy", $time);
    end
    @(posedge clock);
    #1;
    e = sr ? rev(crc, w) : crc;
    if (sc) e = e ^ m;
    `CHK(sum, e)
    $display("test %0d done", t);
  endtask
  task end_sim;
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    #100000;
    err_total++;
    end_sim;
  end
  // ====
  // Tests
  initial begin
    void'($urandom(32'he185));
    repeat (2) @(posedge clock);
    #1;
    srst = 0;
    `CHK({sum, ready, busy}, {32'h0, 2'b10})
    // Test 0 streams words back to back so the buffer backs up
    for (int t = 0; t < 8; t++) begin
      cfg(t);
      for (int n = 0; n < 16; n++) wr($urandom, t == 0 ? 2 : $urandom % 4, t == 0 ? 0 : $urandom % 3 == 0);
      fin(t);
    end
    `CHK(refused > 0, 1'b1)
    for (int s = 0; s < 3; s++) begin
      cfg(s + 1);
      wr($urandom, s, 0);
      fin(8 + s);
      `CHK(cnt, s == 0 ? 2 : s == 1 ? 3 : 5)
    end
    end_sim;
  end
endmodule
